// ### src/lvrc_pkg.sv
// Purpose: shared constants and types of the low-voltage and external reset control block
// Assumes: 40 MHz system clock, registers reached over classic Wishbone with 32-bit data
// Notes:   the status register index is printed as a word index; its byte address is four times it
package lvrc_pkg;

    // register map
    localparam logic [7:0]  PSF_IDX       = 8'h86;
    localparam logic [11:0] PSF_ADDR      = {2'h0, PSF_IDX, 2'h0};

    // field positions of program_status_flags
    localparam int          CAUSE_MSB     = 7;
    localparam int          CAUSE_LSB     = 6;
    localparam int          FLAG_HIGH_POS = 5;
    localparam int          FLAG_MID_POS  = 4;
    localparam int          ALU_MSB       = 2;

    // reset cause codes (upper, lower)
    localparam logic [1:0]  CAUSE_WDT     = 2'h0;
    localparam logic [1:0]  CAUSE_VOLT    = 2'h2;
    localparam logic [1:0]  CAUSE_PIN     = 2'h3;

    // reset values
    localparam logic [1:0]  CAUSE_RST     = CAUSE_VOLT;
    localparam logic        FLAG_RST      = 1'h0;
    localparam logic [2:0]  ALU_RST       = 3'h0;

    // detector option codes
    localparam logic [1:0]  OPT_LOW       = 2'h0;
    localparam logic [1:0]  OPT_MID       = 2'h1;
    localparam logic [1:0]  OPT_HIGH      = 2'h2;
    localparam logic [1:0]  OPT_TOP       = 2'h3;

    // synchroniser reset image: options 0, pin high, detectors reporting low supply
    localparam logic [6:0]  SYNC_RST      = 7'h0F;

    // timing
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          WARM_NS       = 1000;
    localparam int          WARM_CYC      = (WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] START_ADDR    = 12'h000;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_INIT,
        ST_WARM,
        ST_RUN
    } lvrc_state_e;

endpackage

// ### src/lvrc_psf_if.sv
// Purpose: carries the status register between the core and its bus slave
// Assumes: single clock domain
// Notes:   wr_stb is a one-cycle pulse at the edge where the bus master samples ack
`timescale 1ns/1ps
interface lvrc_psf_if;
    logic [7:0] rd_data;
    logic       wr_stb;
    logic [7:0] wr_data;

    modport core (output rd_data, input wr_stb, input wr_data);
    modport bus  (input rd_data, output wr_stb, output wr_data);
endinterface

// ### src/lvrc_sync.sv
// Purpose: two-flop synchronisers, one per bit
// Assumes: inputs are asynchronous levels
// Notes:   the first stage is read only by the second stage
`timescale 1ns/1ps
module lvrc_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                meta_q[i] <= RST_VAL[i];
                dout[i]   <= RST_VAL[i];
            end else begin
                meta_q[i] <= din[i];
                dout[i]   <= meta_q[i];
            end
        end
    end
endmodule

// ### src/lvrc_wb_regs.sv
// Purpose: classic Wishbone slave for the status register
// Assumes: 32-bit data, byte addresses, one register in the low byte lane
// Notes:   ack one cycle after the request, dropped the next cycle; unmapped reads give zero
`timescale 1ns/1ps
module lvrc_wb_regs
    import lvrc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // register side
    lvrc_psf_if.bus          psf
);
    logic        ack_q;
    logic [31:0] dat_q;
    wire         req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire         hit = (wb_adr_i == PSF_ADDR);
    wire [31:0]  rd_word = hit ? {24'h000000, psf.rd_data} : 32'h00000000;

    // write lands on the edge where the master sees ack
    assign psf.wr_stb  = ack_q & wb_cyc_i & wb_stb_i & wb_we_i & hit & wb_sel_i[0];
    assign psf.wr_data = wb_dat_i[7:0];
    assign wb_ack_o    = ack_q;
    assign wb_dat_o    = dat_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= req;
            if (req) begin
                dat_q <= rd_word;
            end
        end
    end
endmodule

// ### src/lvrc_top.sv
// Purpose: low-voltage detector and external reset control, with reset sequence and status flags
// Assumes: detector inputs are high while supply is below their level; watchdog pulse is on clk
// Notes:   option inputs are factory settings, held stable while running
//
// Contract
// - supply below lowest detector level always resets, under every option
// - an enabled reset-class detector reporting low supply resets the system
// - lowest option keeps both low-voltage flags at zero
// - middle option: mid flag follows supply at or below mid level
// - high option: supply below mid level resets instead of flagging
// - high option: high flag follows supply at or below upper level
// - top option: supply below upper level resets; no flags at all
// - high flag in status bit 5, mid flag in bit 4, read-only, zero after reset
// - both flags cleared after any detector-caused reset
// - reset pin acts only when pin option selects reset, else plain input
// - system held in reset while pin low, runs while pin high
// - during power-up a low pin keeps the system in reset
// - after release: initialise, oscillator warm-up, then start at address zero
// - watchdog overflow resets, normal mode after the sequence completes
// - low supply during watchdog reset keeps the system in reset
// - cause in bits 7:6: 00 watchdog, 10 power/detector, 11 pin
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module lvrc_top
    import lvrc_pkg::*;
#(
    parameter int WARM_CYCLES = WARM_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // detectors and watchdog
    input  wire logic        det_2v0_low,
    input  wire logic        det_2v4_low,
    input  wire logic        det_3v6_low,
    input  wire logic        wdt_overflow,
    // reset pin and factory options
    input  wire logic        ext_rst_pin_n,
    input  wire logic        reset_pin_is_reset,
    input  wire logic [1:0]  detector_option,
    // system side
    output logic             sys_rst_n,
    output logic             sys_init,
    output logic             cpu_start,
    output logic      [11:0] start_addr,
    output logic             gpio_in_level,
    output logic             low_volt_flag_mid,
    output logic             low_volt_flag_high,
    output logic      [1:0]  reset_cause
);
    lvrc_psf_if psf ();

    logic [6:0]  sync_out;
    lvrc_state_e st_q;
    lvrc_state_e st_d;
    logic [15:0] warm_cnt_q;
    logic [1:0]  cause_q;
    logic [2:0]  alu_q;
    logic        mid_q;
    logic        high_q;
    logic        run_q;
    logic        init_q;
    logic        start_q;
    logic        gpio_q;

    // pins and detectors are asynchronous to clk
    lvrc_sync #(
        .W       (7),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  ({detector_option, reset_pin_is_reset, ext_rst_pin_n, det_3v6_low, det_2v4_low, det_2v0_low}),
        .dout (sync_out)
    );

    lvrc_wb_regs u_regs (
        .clk      (clk),
        .rstn     (rstn),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .psf      (psf.bus)
    );

    wire       d20_s   = sync_out[0];
    wire       d24_s   = sync_out[1];
    wire       d36_s   = sync_out[2];
    wire       pin_s   = sync_out[3];
    wire       pin_en  = sync_out[4];
    wire [1:0] opt_s   = sync_out[6:5];

    wire opt_mid     = (opt_s == OPT_MID);
    wire opt_high    = (opt_s == OPT_HIGH);
    wire opt_top     = (opt_s == OPT_TOP);
    // lowest level resets regardless of option
    wire rst_2v0     = d20_s;
    wire rst_2v4     = d24_s & (opt_high | opt_top);
    wire rst_3v6     = d36_s & opt_top;
    wire volt_req    = rst_2v0 | rst_2v4 | rst_3v6;
    wire pin_req     = pin_en & ~pin_s;
    wire hold_need   = volt_req | pin_req;
    wire in_run      = (st_q == ST_RUN);
    wire wdt_hit     = in_run & wdt_overflow;
    wire warm_done   = (warm_cnt_q == 16'(WARM_CYCLES - 1));
    wire [1:0] cause_hw = volt_req ? CAUSE_VOLT : (pin_req ? CAUSE_PIN : CAUSE_WDT);
    wire cause_upd   = (st_d == ST_HOLD) & (hold_need | wdt_hit);
    // flags only track in run; any reset, detector-caused included, leaves them clear
    wire mid_d       = in_run & (st_d == ST_RUN) & opt_mid & d24_s;
    wire high_d      = in_run & (st_d == ST_RUN) & opt_high & d36_s;

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_HOLD: begin
                // a watchdog reset lingers here while supply stays low
                if (!hold_need) begin
                    st_d = ST_INIT;
                end
            end
            ST_INIT: begin
                st_d = hold_need ? ST_HOLD : ST_WARM;
            end
            ST_WARM: begin
                if (hold_need) begin
                    st_d = ST_HOLD;
                end else if (warm_done) begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (hold_need || wdt_overflow) begin
                    st_d = ST_HOLD;
                end
            end
            default: begin
                st_d = ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q    <= ST_HOLD;
            run_q   <= 1'b0;
            init_q  <= 1'b0;
            start_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            run_q   <= (st_d == ST_RUN);
            init_q  <= (st_d == ST_INIT);
            start_q <= (st_q == ST_WARM) & (st_d == ST_RUN);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            warm_cnt_q <= 16'h0000;
        end else if (st_q == ST_WARM) begin
            warm_cnt_q <= warm_cnt_q + 16'h0001;
        end else begin
            warm_cnt_q <= 16'h0000;
        end
    end

    // cause: hardware update wins over a software write in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cause_q <= CAUSE_RST;
        end else if (cause_upd) begin
            cause_q <= cause_hw;
        end else if (psf.wr_stb) begin
            cause_q <= psf.wr_data[CAUSE_MSB:CAUSE_LSB];
        end
    end

    // arithmetic flags belong to the cpu; the reset sequence initialises them
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alu_q <= ALU_RST;
        end else if (st_q == ST_INIT) begin
            alu_q <= ALU_RST;
        end else if (psf.wr_stb) begin
            alu_q <= psf.wr_data[ALU_MSB:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mid_q  <= FLAG_RST;
            high_q <= FLAG_RST;
            gpio_q <= 1'b0;
        end else begin
            mid_q  <= mid_d;
            high_q <= high_d;
            gpio_q <= ~pin_en & pin_s;
        end
    end

    // flag bits are read-only: writes never reach them
    assign psf.rd_data        = {cause_q, high_q, mid_q, 1'b0, alu_q};
    assign sys_rst_n          = run_q;
    assign sys_init           = init_q;
    assign cpu_start          = start_q;
    assign start_addr         = START_ADDR;
    assign gpio_in_level      = gpio_q;
    assign low_volt_flag_mid  = mid_q;
    assign low_volt_flag_high = high_q;
    assign reset_cause        = cause_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // a fresh request during init legally restarts from hold, so only a quiet init must move on
    sequence s_init_step;
        (st_q == ST_INIT) && sys_init && !hold_need;
    endsequence

    sequence s_enter_init;
        (st_q == ST_HOLD) && !hold_need;
    endsequence

    a_deep_low_reset: assert property (d20_s |=> !sys_rst_n)
        else $error("lowest detector level did not reset");

    a_enabled_det_reset: assert property ((rst_2v4 || rst_3v6) |=> !sys_rst_n)
        else $error("enabled detector did not reset");

    a_low_opt_flags: assert property ((opt_s == OPT_LOW) |=> !low_volt_flag_mid && !low_volt_flag_high)
        else $error("flag set under lowest option");

    a_mid_flag_track: assert property ((opt_mid && in_run && !hold_need && !wdt_overflow)
        |=> low_volt_flag_mid == $past(d24_s))
        else $error("mid flag does not follow supply");

    a_high_mid_reset: assert property ((opt_high && d24_s) |=> !sys_rst_n && !low_volt_flag_high)
        else $error("high option did not reset at mid level");

    a_high_flag_track: assert property ((opt_high && in_run && !hold_need && !wdt_overflow)
        |=> low_volt_flag_high == $past(d36_s))
        else $error("high flag does not follow supply");

    a_top_no_flags: assert property (opt_top |=> !low_volt_flag_mid && !low_volt_flag_high)
        else $error("flag set under top option");

    a_flag_bits_map: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == PSF_ADDR)
        |=> wb_dat_o[FLAG_HIGH_POS] == $past(low_volt_flag_high) && wb_dat_o[FLAG_MID_POS] == $past(low_volt_flag_mid))
        else $error("flag bits misplaced");

    a_volt_clear: assert property ((st_q == ST_HOLD && volt_req)
        |=> !low_volt_flag_mid && !low_volt_flag_high && reset_cause == CAUSE_VOLT)
        else $error("flags not cleared by detector reset");

    a_pin_ignored: assert property ((!pin_en && in_run && !volt_req && !wdt_overflow) |=> sys_rst_n)
        else $error("pin reset while pin is an input");

    a_pin_hold: assert property (pin_req |=> !sys_rst_n [*2])
        else $error("low reset pin did not hold reset");

    a_boot_order: assert property (s_enter_init ##1 s_init_step |=> !sys_init && st_q == ST_WARM && !sys_rst_n)
        else $error("release did not initialise then warm up");

    a_warm_length: assert property (cpu_start |-> sys_rst_n && $past(warm_done))
        else $error("program started before warm-up ended");

    a_wdt_reset: assert property ((wdt_hit && !hold_need)
        |=> !sys_rst_n && reset_cause == CAUSE_WDT ##1 st_q == ST_INIT)
        else $error("watchdog overflow did not reset");

    a_wdt_low_stay: assert property ((st_q == ST_HOLD && volt_req) |=> st_q == ST_HOLD)
        else $error("left reset while supply low");

    a_pin_cause: assert property ((st_q == ST_HOLD && !volt_req && pin_req) |=> reset_cause == CAUSE_PIN)
        else $error("pin reset cause not recorded");

    a_sync_release: assert property ($rose(sys_rst_n) |-> $past(st_q) == ST_WARM && cpu_start)
        else $error("reset released outside sequence");

endmodule

// ### tb/lvrc_top_bench.sv
// Purpose: self-checking bench for the low-voltage and external reset control block
// Assumes: warm-up shortened to WARM cycles; status register reached at its byte address
// Notes:   options and detector levels drawn from a fixed seed, with directed corner cases
`timescale 1ns/1ps
module lvrc_top_bench
    import lvrc_pkg::*;
;
    localparam int WARM = 3;

    // bus
    logic        clk;
    logic        rstn;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    // detectors, pin, options
    logic        det20;
    logic        det24;
    logic        det36;
    logic        wdt;
    logic        pin_n;
    logic        pin_rst;
    logic [1:0]  opt;
    // system side
    logic        sys_rst_n;
    logic        sys_init;
    logic        cpu_start;
    logic [11:0] start_addr;
    logic        gpio;
    logic        fmid;
    logic        fhigh;
    logic [1:0]  cause;
    int          err_count;
    int          samples_checked;

    lvrc_top #(.WARM_CYCLES(WARM)) dut (
        .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .det_2v0_low(det20),
        .det_2v4_low(det24), .det_3v6_low(det36), .wdt_overflow(wdt), .ext_rst_pin_n(pin_n),
        .reset_pin_is_reset(pin_rst), .detector_option(opt), .sys_rst_n(sys_rst_n),
        .sys_init(sys_init), .cpu_start(cpu_start), .start_addr(start_addr),
        .gpio_in_level(gpio), .low_volt_flag_mid(fmid), .low_volt_flag_high(fhigh),
        .reset_cause(cause)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic hang(input string what);
        err_count++;
        $display("[ERR] %0t timeout waiting for %s", $time, what);
        end_of_test();
    endtask

    // classic cycle: hold everything until ack is sampled, then release for one idle cycle
    task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) hang("ack");
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 4'hF, 32'h0, q);
        chk(q, e, "status read");
    endtask

    task automatic wait_run();
        int n;
        n = 0;
        while (sys_rst_n !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 300) hang("run");
    endtask

    // the one place that raises the watchdog overflow, one cycle wide
    task automatic wdt_pulse();
        @(posedge clk);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
    endtask

    function automatic logic exp_rst(logic [1:0] o, logic a, logic b, logic c);
        return a | (o >= OPT_HIGH && b) | (o == OPT_TOP && c);
    endfunction

    // levels applied together; flags must read zero whenever a reset is in force
    task automatic det_case(input logic [1:0] o, input logic a, input logic b, input logic c);
        logic r;
        r = exp_rst(o, a, b, c);
        @(posedge clk);
        opt   <= o;
        det20 <= a;
        det24 <= b;
        det36 <= c;
        repeat (6) @(posedge clk);
        #1;
        chk(sys_rst_n, !r, "system reset");
        chk(fmid, !r && o == OPT_MID && b, "mid flag");
        chk(fhigh, !r && o == OPT_HIGH && c, "high flag");
        if (r) chk(cause, CAUSE_VOLT, "detector cause");
        @(posedge clk);
        det20 <= 1'b0;
        det24 <= 1'b0;
        det36 <= 1'b0;
        wait_run();
        repeat (4) @(posedge clk);
        #1;
        chk({fhigh, fmid}, 2'h0, "flags after recovery");
    endtask

    initial begin
        logic [31:0] d;
        logic [31:0] q;
        int          n;
        logic        seen;
        {cyc, stb, we, wdt, det20, det24, det36} = '0;
        adr = '0;
        sel = '0;
        wdat = '0;
        pin_n = 1'b1;
        pin_rst = 1'b1;
        opt = OPT_LOW;
        rstn = 1'b0;
        err_count = 0;
        samples_checked = 0;
        void'($urandom(32'hC449));
        repeat (10) @(posedge clk);
        #1;
        chk({sys_rst_n, fhigh, fmid, cause}, {3'h0, CAUSE_RST}, "values in reset");
        @(posedge clk);
        rstn <= 1'b1;
        wait_run();
        chk({cpu_start, start_addr}, {1'b1, START_ADDR}, "start at zero");
        rd_chk(PSF_ADDR, {24'h0, CAUSE_VOLT, 2'h0, 1'b0, ALU_RST});
        $display("test power-on done");

        // registers: flags and bit 3 ignore writes, low lane only, unmapped reads zero
        wb(1'b1, PSF_ADDR, 4'h1, 32'hFF, q);
        rd_chk(PSF_ADDR, 32'hC7);
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            wb(1'b1, PSF_ADDR, 4'h1, d, q);
            wb(1'b1, PSF_ADDR, 4'hE, ~d, q);
            rd_chk(PSF_ADDR, {24'h0, d[7:6], 3'h0, d[2:0]});
        end
        wb(1'b1, 12'h000, 4'hF, 32'hFF, q);
        rd_chk(12'h000, 32'h0);
        $display("test registers done");

        for (int o = 0; o < 4; o++) begin
            for (int k = 0; k < 4; k++) begin
                det_case(o[1:0], k == 1, k == 2, k == 3);
            end
        end
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            det_case(d[1:0], d[2] & d[3], d[4], d[5]);
        end
        $display("test detector options done");

        // watchdog pulse in run, then the full sequence back to run
        opt <= OPT_LOW;
        wdt_pulse();
        #1;
        chk({sys_rst_n, cause}, {1'b0, CAUSE_WDT}, "watchdog reset");
        n = 0;
        seen = 1'b0;
        while (sys_rst_n !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
            if (sys_init === 1'b1) seen = 1'b1;
        end
        if (n >= 100) hang("watchdog run");
        chk(n, WARM + 2, "watchdog sequence length");
        chk({seen, cpu_start}, 2'h3, "init then start");
        rd_chk(PSF_ADDR, {24'h0, CAUSE_WDT, 6'h0});
        // watchdog pulse, then the supply drops too low during the reset sequence
        wdt_pulse();
        det20 <= 1'b1;
        repeat (30) @(posedge clk);
        #1;
        chk(sys_rst_n, 1'b0, "held by low supply");
        det20 <= 1'b0;
        wait_run();
        $display("test watchdog done");

        // external pin as reset, then as plain input
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk({sys_rst_n, cause}, {1'b0, CAUSE_PIN}, "pin reset");
        repeat (20) @(posedge clk);
        #1;
        chk(sys_rst_n, 1'b0, "pin still low");
        pin_n <= 1'b1;
        wait_run();
        rd_chk(PSF_ADDR, {24'h0, CAUSE_PIN, 6'h0});
        pin_rst <= 1'b0;
        pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk({sys_rst_n, gpio}, 2'h2, "pin as input low");
        pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk({sys_rst_n, gpio}, 2'h3, "pin as input high");
        $display("test pin done");

        // power-up with the pin held low stays in reset
        pin_rst <= 1'b1;
        pin_n <= 1'b0;
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (60) @(posedge clk);
        #1;
        chk(sys_rst_n, 1'b0, "power-up pin low");
        pin_n <= 1'b1;
        wait_run();
        chk(cpu_start, 1'b1, "start after pin release");
        $display("test power-up pin done");
        end_of_test();
    end
endmodule
